// File: hw/spi_cmd_pkg.sv
// Shared constants for the serial EEPROM command, status and protection ends.
// Assumes both ends run on one 125 MHz reference clock and the link is a 4-wire serial bus.
package spi_cmd_pkg;

   // Instruction opcodes.
   localparam logic [7:0] OP_ENABLE_WRITES = 8'h06;
   localparam logic [7:0] OP_DISABLE_WRITES = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_MEM_READ = 8'h03;
   localparam logic [7:0] OP_MEM_WRITE = 8'h02;

   // Status byte bit positions.
   localparam int unsigned ST_LOCK_BIT = 7;
   localparam int unsigned ST_SEL_HI_BIT = 3;
   localparam int unsigned ST_SEL_LO_BIT = 2;
   localparam int unsigned ST_LATCH_BIT = 1;
   localparam int unsigned ST_BUSY_BIT = 0;

   // Address width and protected-region lower bounds.
   localparam int unsigned ADDR_W = 17;
   localparam logic [16:0] PROT_QUARTER_BASE = 17'h1_8000;
   localparam logic [16:0] PROT_HALF_BASE = 17'h1_0000;
   localparam logic [16:0] PROT_WHOLE_BASE = 17'h0_0000;

   // Frame byte counts: opcode, then three address bytes.
   localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
   localparam logic [2:0] BYTES_ADDR_DONE = 3'h4;
   localparam logic [2:0] BYTES_MIN_WRITE = 3'h5;
   localparam logic [2:0] BYTES_SAT = 3'h7;

   // Timing.
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned WRITE_TIME_NS_DEF = 1000000;
   localparam int unsigned SPI_PERIOD_NS = 160;
   localparam int unsigned HOST_HALF_CYCLES = SPI_PERIOD_NS / 2 / CLK_PERIOD_NS;

   // Reset values.
   localparam logic [7:0] STATUS_RESET = 8'h00;

endpackage : spi_cmd_pkg

// File: hw/spi_link_if.sv
// Serial link between the EEPROM command end and the bus master end.
// Assumes the data-out line has a pull-up: it reads high when the device does not drive it.
`timescale 1ns/1ps
interface spi_link_if;
   logic sclk;       // Serial clock driven by the master.
   logic cs_n;       // Chip select, active low.
   logic mosi;       // Master to device data.
   logic miso;       // Device to master data value.
   logic miso_oe;    // High while the device drives the data-out line.
   logic wp_n;       // Write protect pin, active low.
   logic miso_line;  // Resolved level on the data-out wire.

   // The pull-up gives a defined level while the device is off the line.
   assign miso_line = miso_oe ? miso : 1'b1;

   modport device_mp (input sclk, input cs_n, input mosi, input wp_n,
                      output miso, output miso_oe);
   modport host_mp (output sclk, output cs_n, output mosi, output wp_n,
                    input miso_line);
endinterface : spi_link_if

// File: hw/spi_eeprom_dev.sv
// Command decoder, status register and write protection of the serial EEPROM.
// Assumes the link pins are asynchronous to ref_clk_in and much slower than it.
`timescale 1ns/1ps
module spi_eeprom_dev #(
   parameter int unsigned WRITE_TIME_NS = spi_cmd_pkg::WRITE_TIME_NS_DEF
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Serial link.
   spi_link_if.device_mp link,
   // Non-volatile cells {lock, sel_hi, sel_lo}.
   input wire logic [2:0] nv_stored_in,
   output logic [2:0] nv_stored_out,
   // Status and hand-off to the memory array.
   output logic [7:0] status_out,
   output logic hard_protect_out,
   output logic mem_write_go_out,
   output logic [16:0] mem_write_addr_out
);

   // Self-timed write length, rounded up to whole cycles.
   localparam int unsigned WRITE_CYCLES =
      (WRITE_TIME_NS + spi_cmd_pkg::CLK_PERIOD_NS - 1) / spi_cmd_pkg::CLK_PERIOD_NS;

   // Frame states, one-hot.
   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_OPCODE = 8'b0000_0010,
      ST_ADDR = 8'b0000_0100,
      ST_MEMDATA = 8'b0000_1000,
      ST_STDATA = 8'b0001_0000,
      ST_STREAD = 8'b0010_0000,
      ST_WAIT = 8'b0100_0000,
      ST_IGNORE = 8'b1000_0000
   } frame_state_t;

   frame_state_t state;          // Current frame state.
   logic sclk_s1, sclk_s2, sclk_s3; // Serial clock synchroniser and edge stage.
   logic cs_s1, cs_s2, cs_s3;    // Chip select synchroniser and edge stage.
   logic mosi_s1, mosi_s2;       // Data-in synchroniser.
   logic wp_s1, wp_s2;           // Write protect synchroniser.
   logic nv_loaded;              // Stored bits have been fetched after reset.
   logic armed;                  // Chip select was seen high since reset.
   logic [2:0] bit_cnt;          // Bit position within the current byte.
   logic [2:0] byte_cnt;         // Completed bytes in the frame, saturating.
   logic [31:0] frame;           // Last four bytes shifted in.
   logic [7:0] op_q;             // Opcode of the current frame.
   logic [16:0] addr_q;          // Start address of a memory instruction.
   logic lock, sel_hi, sel_lo;   // Non-volatile status bits.
   logic latch, busy;            // Volatile status bits.
   logic pend_status;            // Running cycle is a status write.
   logic [2:0] pend_nv;          // Status bits waiting for cycle end.
   logic [31:0] wait_cnt;        // Self-timed cycle counter.
   logic [2:0] out_idx;          // Next status bit to drive.
   logic miso_q;                 // Registered data-out value.
   logic [7:0] next_byte;        // Byte completed by this rising edge.
   logic sclk_rise, sclk_fall, cs_rise, cs_fall;
   logic hard_protect_mode, in_prot, status_write_cmd_ok, write_ok, exec_en, exec_dis, cycle_done;
   logic [7:0] status_byte;

   // Every pin passes two flops; edges compare the second and third stage only.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
         wp_s1 <= 1'b1;
         wp_s2 <= 1'b1;
      end else begin
         sclk_s1 <= link.sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_s1 <= link.cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         mosi_s1 <= link.mosi;
         mosi_s2 <= mosi_s1;
         wp_s1 <= link.wp_n;
         wp_s2 <= wp_s1;
      end
   end

   // Input bits are taken on rising edges and output bits move on falling ones.
   assign sclk_rise = sclk_s2 & ~sclk_s3;
   assign sclk_fall = ~sclk_s2 & sclk_s3;
   assign cs_rise = cs_s2 & ~cs_s3;
   assign cs_fall = ~cs_s2 & cs_s3;
   assign next_byte = {frame[6:0], mosi_s2};

   // Hard protection is a live AND, so whichever input comes last enters it.
   assign hard_protect_mode = lock & ~wp_s2;

   // Region check against the start address.
   always_comb begin
      case ({sel_hi, sel_lo})
         2'b01: in_prot = (addr_q >= spi_cmd_pkg::PROT_QUARTER_BASE);
         2'b10: in_prot = (addr_q >= spi_cmd_pkg::PROT_HALF_BASE);
         2'b11: in_prot = (addr_q >= spi_cmd_pkg::PROT_WHOLE_BASE);
         default: in_prot = 1'b0;
      endcase
   end

   // Deselect decisions; each requires chip select to rise on an exact byte end.
   assign exec_en = cs_rise & (state == ST_WAIT) & (op_q == spi_cmd_pkg::OP_ENABLE_WRITES);
   assign exec_dis = cs_rise & (state == ST_WAIT) & (op_q == spi_cmd_pkg::OP_DISABLE_WRITES);
   assign status_write_cmd_ok = cs_rise & (state == ST_STDATA) & (bit_cnt == 3'h0)
                  & (byte_cnt == spi_cmd_pkg::BYTES_STATUS_WRITE)
                  & latch & ~hard_protect_mode & ~busy;
   assign write_ok = cs_rise & (state == ST_MEMDATA) & (bit_cnt == 3'h0)
                   & (byte_cnt >= spi_cmd_pkg::BYTES_MIN_WRITE)
                   & latch & ~busy & ~in_prot;
   assign cycle_done = busy & (wait_cnt == 32'(WRITE_CYCLES - 1));

   // Stored bits are fetched once, on the first edge after reset release.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         nv_loaded <= 1'b0;
         armed <= 1'b0;
      end else begin
         nv_loaded <= 1'b1;
         // A selection only counts after chip select has been high once.
         if (nv_loaded && cs_s2) begin
            armed <= 1'b1;
         end
      end
   end

   // Frame tracking and opcode decode.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= ST_IDLE;
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         frame <= 32'h0000_0000;
         op_q <= 8'h00;
         addr_q <= 17'h0_0000;
      end else if (cs_rise || !armed) begin
         state <= ST_IDLE;
      end else if (cs_fall) begin
         state <= ST_OPCODE;
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
      end else if (sclk_rise && state != ST_IDLE && state != ST_IGNORE) begin
         frame <= {frame[30:0], mosi_s2};
         bit_cnt <= bit_cnt + 3'h1;
         // A bit past the end of an enable or disable voids it.
         if (state == ST_WAIT) begin
            state <= ST_IGNORE;
         end
         if (bit_cnt == 3'h7) begin
            if (byte_cnt != spi_cmd_pkg::BYTES_SAT) begin
               byte_cnt <= byte_cnt + 3'h1;
            end
            if (state == ST_OPCODE) begin
               op_q <= next_byte;
               // While busy only the status read is served.
               if (next_byte == spi_cmd_pkg::OP_STATUS_READ) begin
                  state <= ST_STREAD;
               end else if (busy) begin
                  state <= ST_IGNORE;
               end else if (next_byte == spi_cmd_pkg::OP_ENABLE_WRITES
                            || next_byte == spi_cmd_pkg::OP_DISABLE_WRITES) begin
                  state <= ST_WAIT;
               end else if (next_byte == spi_cmd_pkg::OP_STATUS_WRITE) begin
                  state <= ST_STDATA;
               end else if (next_byte == spi_cmd_pkg::OP_MEM_READ
                            || next_byte == spi_cmd_pkg::OP_MEM_WRITE) begin
                  state <= ST_ADDR;
               end else begin
                  state <= ST_IGNORE;
               end
            end else if (state == ST_ADDR && byte_cnt == spi_cmd_pkg::BYTES_ADDR_DONE - 3'h1) begin
               // High address bits are dropped.
               addr_q <= {frame[15:0], mosi_s2};
               state <= (op_q == spi_cmd_pkg::OP_MEM_WRITE) ? ST_MEMDATA : ST_IGNORE;
            end
         end
      end
   end

   // Write latch: set by the enable command only, cleared by the listed events.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         latch <= 1'b0;
      end else if (exec_en) begin
         latch <= 1'b1;
      end else if (exec_dis || (cycle_done && !status_write_cmd_ok && !write_ok)) begin
         latch <= 1'b0;
      end
   end

   // Self-timed cycle, shared by memory and status writes.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy <= 1'b0;
         wait_cnt <= 32'h0000_0000;
         pend_status <= 1'b0;
         pend_nv <= 3'h0;
         mem_write_go_out <= 1'b0;
         mem_write_addr_out <= 17'h0_0000;
      end else begin
         mem_write_go_out <= write_ok;
         if (status_write_cmd_ok || write_ok) begin
            busy <= 1'b1;
            wait_cnt <= 32'h0000_0000;
            pend_status <= status_write_cmd_ok;
            // Only bits 7, 3 and 2 of the data byte are kept.
            pend_nv <= {frame[spi_cmd_pkg::ST_LOCK_BIT], frame[spi_cmd_pkg::ST_SEL_HI_BIT],
                        frame[spi_cmd_pkg::ST_SEL_LO_BIT]};
            mem_write_addr_out <= addr_q;
         end else if (cycle_done) begin
            busy <= 1'b0;
         end else if (busy) begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
         end
      end
   end

   // Non-volatile bits change only at the end of an accepted status write.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lock <= 1'b0;
         sel_hi <= 1'b0;
         sel_lo <= 1'b0;
      end else if (!nv_loaded) begin
         {lock, sel_hi, sel_lo} <= nv_stored_in;
      end else if (cycle_done && pend_status) begin
         {lock, sel_hi, sel_lo} <= pend_nv;
      end
   end

   // Status layout; bits 6 to 4 are hard zeros.
   always_comb begin
      status_byte = spi_cmd_pkg::STATUS_RESET;
      status_byte[spi_cmd_pkg::ST_LOCK_BIT] = lock;
      status_byte[spi_cmd_pkg::ST_SEL_HI_BIT] = sel_hi;
      status_byte[spi_cmd_pkg::ST_SEL_LO_BIT] = sel_lo;
      status_byte[spi_cmd_pkg::ST_LATCH_BIT] = latch;
      status_byte[spi_cmd_pkg::ST_BUSY_BIT] = busy;
   end

   // Status read drives the live byte MSB first and wraps for as long as selected.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_idx <= 3'h7;
         miso_q <= 1'b0;
      end else if (cs_fall) begin
         out_idx <= 3'h7;
      end else if (sclk_fall && state == ST_STREAD) begin
         miso_q <= status_byte[out_idx];
         out_idx <= out_idx - 3'h1;
      end
   end

   // Outputs.
   assign link.miso = miso_q;
   assign link.miso_oe = (state == ST_STREAD);
   assign status_out = status_byte;
   assign hard_protect_out = hard_protect_mode;
   assign nv_stored_out = {lock, sel_hi, sel_lo};

endmodule : spi_eeprom_dev

// File: hw/spi_eeprom_host.sv
// Bus master end: frames one instruction per command onto the serial link.
// Assumes the user holds command fields stable while cmd_valid_in is high.
`timescale 1ns/1ps
module spi_eeprom_host (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Serial link.
   spi_link_if.host_mp link,
   // Write protect level to put on the pin.
   input wire logic wp_n_in,
   // Command request.
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic [7:0] cmd_opcode_in,
   input wire logic [2:0] cmd_extra_in,
   input wire logic [31:0] cmd_payload_in,
   // Answer.
   output logic rsp_valid_out,
   output logic [7:0] rsp_byte_out
);

   // Master states, one-hot.
   typedef enum logic [4:0] {
      H_IDLE = 5'b0_0001,
      H_LOW = 5'b0_0010,
      H_HIGH = 5'b0_0100,
      H_DESEL = 5'b0_1000,
      H_DONE = 5'b1_0000
   } host_state_t;

   host_state_t state;   // Current master state.
   logic [39:0] tx;      // Opcode and payload, MSB first.
   logic [5:0] bits_left; // Bits still to clock.
   logic [7:0] half_cnt; // Half-period timer.
   logic [7:0] rx;       // Last eight bits received.
   logic miso_s1, miso_s2; // Data-in synchroniser.
   logic half_end;       // Half period elapsed.
   logic [2:0] extra;    // Payload byte count, clamped to four.

   assign half_end = (half_cnt == 8'(spi_cmd_pkg::HOST_HALF_CYCLES - 1));
   assign extra = (cmd_extra_in > 3'h4) ? 3'h4 : cmd_extra_in;

   // Data-in comes from the pin, so it is synchronised first.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         miso_s1 <= 1'b1;
         miso_s2 <= 1'b1;
      end else begin
         miso_s1 <= link.miso_line;
         miso_s2 <= miso_s1;
      end
   end

   // Half-period timer, restarted on each phase change.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         half_cnt <= 8'h00;
      end else if (state == H_IDLE || half_end) begin
         half_cnt <= 8'h00;
      end else begin
         half_cnt <= half_cnt + 8'h01;
      end
   end

   // Frame sequencer; the clock idles low, so this is the idle-low mode.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= H_IDLE;
         tx <= 40'h00_0000_0000;
         bits_left <= 6'h00;
         rx <= 8'h00;
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
         link.mosi <= 1'b0;
         rsp_valid_out <= 1'b0;
         rsp_byte_out <= 8'h00;
      end else begin
         rsp_valid_out <= 1'b0;
         case (state)
            H_IDLE: begin
               if (cmd_valid_in) begin
                  // Payload bytes follow the opcode, most significant first.
                  tx <= {cmd_opcode_in, cmd_payload_in};
                  bits_left <= {extra, 3'h0} + 6'h08;
                  link.cs_n <= 1'b0;
                  link.mosi <= cmd_opcode_in[7];
                  state <= H_LOW;
               end
            end
            H_LOW: begin
               if (half_end) begin
                  // Rising edge: the device takes mosi, we take miso.
                  link.sclk <= 1'b1;
                  rx <= {rx[6:0], miso_s2};
                  bits_left <= bits_left - 6'h01;
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (half_end) begin
                  link.sclk <= 1'b0;
                  if (bits_left == 6'h00) begin
                     // Deselect after the last rising edge, before another.
                     link.cs_n <= 1'b1;
                     state <= H_DESEL;
                  end else begin
                     tx <= {tx[38:0], 1'b0};
                     link.mosi <= tx[38];
                     state <= H_LOW;
                  end
               end
            end
            H_DESEL: begin
               // Hold chip select high for a half period between frames.
               if (half_end) begin
                  state <= H_DONE;
               end
            end
            H_DONE: begin
               rsp_valid_out <= 1'b1;
               rsp_byte_out <= rx;
               state <= H_IDLE;
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end

   // Busy polling is left to the user; the master issues whatever it is given.
   assign cmd_ready_out = (state == H_IDLE);
   assign link.wp_n = wp_n_in;

endmodule : spi_eeprom_host

// File: dv/spi_link_properties.sv
// Checker for the serial link wires between the host end and the device end.
// Assumes one reference clock domain; the bench places it beside the link.
`timescale 1ns/1ps
module spi_link_properties (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Link wires.
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic mosi_in,
   input wire logic miso_in,
   input wire logic miso_oe_in,
   input wire logic wp_n_in,
   input wire logic miso_line_in
);
   logic [5:0] rises; // Rising serial clock edges seen in this frame.
   logic sclk_q; // Serial clock one reference cycle ago.
   // Counting at the pin runs ahead of the device's synchronisers, which is safe here.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rises <= 6'h00;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk_in;
         rises <= cs_n_in ? 6'h00 : rises + 6'(sclk_in && !sclk_q);
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   property p_idle; cs_n_in |-> !sclk_in; endproperty
   a_idle: assert property (p_idle) else $error("clock high while idle");
   property p_half; $rose(sclk_in) |=> sclk_in [*8]; endproperty
   a_half: assert property (p_half) else $error("short clock high half");
   property p_mosi; sclk_in && $past(sclk_in) |-> $stable(mosi_in); endproperty
   a_mosi: assert property (p_mosi) else $error("data in moved while clock high");
   property p_miso; sclk_in && $past(sclk_in) && $past(miso_oe_in) |-> $stable(miso_in);
   endproperty
   a_miso: assert property (p_miso) else $error("data out moved while clock high");
   property p_sel; $changed(cs_n_in) |-> !sclk_in; endproperty
   a_sel: assert property (p_sel) else $error("select moved while clock high");
   property p_bytes; $rose(cs_n_in) |-> rises[2:0] == 3'h0; endproperty
   a_bytes: assert property (p_bytes) else $error("frame not whole bytes");
   property p_oe_on; $rose(miso_oe_in) |-> !cs_n_in && sclk_in && rises == 6'h08; endproperty
   a_oe_on: assert property (p_oe_on) else $error("output enable not after opcode");
   property p_oe_off; cs_n_in [*5] |-> !miso_oe_in && miso_line_in; endproperty
   a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
   c_read: cover property ($rose(miso_oe_in));
   c_frame: cover property ($rose(cs_n_in) && rises == 6'h10);
   c_low: cover property (!miso_line_in && !wp_n_in);
endmodule : spi_link_properties

// File: dv/tb.sv
// Bench: host and device ends joined on one link, driven through the host command port.
// Assumes the package, the link interface and both ends are compiled first.
`timescale 1ns/1ps
module tb;
   localparam logic [16:0] ADDRS [4] = '{17'h0_FFFF, 17'h1_0000, 17'h1_7FFF, 17'h1_8000};
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic wp_n_in = 1'b1;
   logic cmd_valid_in = 1'b0;
   logic [7:0] cmd_opcode_in = 8'h00;
   logic [2:0] cmd_extra_in = 3'h0;
   logic [31:0] cmd_payload_in = 32'h0000_0000;
   logic [2:0] nv_stored_in = 3'h0;
   logic cmd_ready_out, rsp_valid_out, hard_protect_out, mem_write_go_out;
   logic [7:0] rsp_byte_out, status_out, rsp;
   logic [2:0] nv_stored_out;
   logic [16:0] mem_write_addr_out, go_addr;
   logic lock, latch; // Expected lock bit and write latch.
   logic [1:0] sel; // Expected protect selection.
   int bad_count = 0, n_tests = 0, go_cnt = 0;
   spi_link_if u_spi_link_if ();
   spi_eeprom_dev #(.WRITE_TIME_NS(800)) u_spi_eeprom_dev (.ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in), .link(u_spi_link_if.device_mp), .nv_stored_in(nv_stored_in),
      .nv_stored_out(nv_stored_out), .status_out(status_out), .hard_protect_out(hard_protect_out),
      .mem_write_go_out(mem_write_go_out), .mem_write_addr_out(mem_write_addr_out));
   spi_eeprom_host u_spi_eeprom_host (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .link(u_spi_link_if.host_mp), .wp_n_in(wp_n_in), .cmd_valid_in(cmd_valid_in),
      .cmd_ready_out(cmd_ready_out), .cmd_opcode_in(cmd_opcode_in), .cmd_extra_in(cmd_extra_in),
      .cmd_payload_in(cmd_payload_in), .rsp_valid_out(rsp_valid_out), .rsp_byte_out(rsp_byte_out));
   spi_link_properties u_spi_link_properties (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .sclk_in(u_spi_link_if.sclk), .cs_n_in(u_spi_link_if.cs_n), .mosi_in(u_spi_link_if.mosi),
      .miso_in(u_spi_link_if.miso), .miso_oe_in(u_spi_link_if.miso_oe),
      .wp_n_in(u_spi_link_if.wp_n), .miso_line_in(u_spi_link_if.miso_line));
   // The clock toggles every half period of 4 ns.
   always #4 ref_clk_in = ~ref_clk_in;
   // Count start pulses so that a refused write is seen as no pulse at all.
   always @(posedge ref_clk_in) begin
      if (mem_write_go_out === 1'b1) begin
         go_cnt++;
         go_addr = mem_write_addr_out;
      end
   end
   // The status byte that the rules predict while no cycle runs.
   function automatic logic [7:0] st();
      return {lock, 3'h0, sel, latch, 1'b0};
   endfunction : st
   // True where the selection guards the address.
   function automatic logic prot(input logic [1:0] s, input logic [16:0] a);
      case (s)
         2'h1: return a >= spi_cmd_pkg::PROT_QUARTER_BASE;
         2'h2: return a >= spi_cmd_pkg::PROT_HALF_BASE;
         2'h3: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : prot
   task automatic summarize();
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_addr(input logic [16:0] got, input logic [16:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_addr
   // One command through the host; a lost answer counts as a mismatch.
   task automatic send(input logic [7:0] op, input logic [2:0] n, input logic [31:0] pl);
      int i;
      @(negedge ref_clk_in);
      cmd_valid_in = 1'b1;
      cmd_opcode_in = op;
      cmd_extra_in = n;
      cmd_payload_in = pl;
      i = 0;
      while (cmd_ready_out !== 1'b1 && i < 100) begin
         @(negedge ref_clk_in);
         i++;
      end
      @(negedge ref_clk_in);
      cmd_valid_in = 1'b0;
      i = 0;
      do begin
         @(posedge ref_clk_in);
         #1;
         i++;
      end while (rsp_valid_out !== 1'b1 && i < 2000);
      if (i >= 2000) bad_count++;
      rsp = rsp_byte_out;
   endtask : send
   // Two status bytes are read so the repeat of the byte is what gets compared.
   task automatic rd_chk();
      send(8'h05, 3'h2, 32'h0000_0000);
      chk_byte(rsp, st());
   endtask : rd_chk
   task automatic en();
      send(8'h06, 3'h0, 32'h0000_0000);
      latch = 1'b1;
   endtask : en
   // Busy is sampled just after the frame, long before the shortened cycle ends.
   task automatic status_write_cmd(input logic [7:0] d, input logic [2:0] n);
      logic ok;
      ok = latch && n == 3'h1 && !(lock && !wp_n_in);
      send(8'h01, n, {d, 24'h00_0000});
      chk_byte(status_out, st() | {7'h00, ok});
      // Let the cycle finish before the next instruction, as the master should.
      repeat (120) @(posedge ref_clk_in);
      if (ok) begin
         lock = d[7];
         sel = d[3:2];
         latch = 1'b0;
      end
      rd_chk();
   endtask : status_write_cmd
   task automatic memwr(input logic [16:0] a);
      int c;
      logic ok;
      c = go_cnt;
      ok = latch && !prot(sel, a);
      send(8'h02, 3'h4, {7'($urandom), a, 8'($urandom)});
      repeat (120) @(posedge ref_clk_in);
      chk_byte(8'(go_cnt - c), {7'h00, ok});
      if (ok) chk_addr(go_addr, a);
      if (ok) latch = 1'b0;
      chk_byte(status_out, st());
   endtask : memwr
   initial begin
      #720000;
      bad_count++;
      summarize();
   end
   initial begin
      logic [7:0] d;
      void'($urandom(81515));
      nv_stored_in = 3'($urandom);
      {lock, sel} = nv_stored_in;
      latch = 1'b0;
      repeat (12) @(posedge ref_clk_in);
      @(negedge ref_clk_in) reset_n_in = 1'b1;
      repeat (8) @(negedge ref_clk_in);
      rd_chk();
      send(8'h06, 3'h1, 32'h0000_0000);
      rd_chk();
      en();
      rd_chk();
      send(8'h04, 3'h0, 32'h0000_0000);
      latch = 1'b0;
      rd_chk();
      status_write_cmd(8'($urandom), 3'h1);
      en();
      status_write_cmd(8'($urandom), 3'h2);
      status_write_cmd(8'($urandom), 3'h1);
      d = 8'($urandom);
      if (d inside {[8'h01:8'h06]}) d = 8'hA5;
      send(d, 3'h2, 32'h0506_0000);
      chk_byte(rsp, 8'hFF);
      rd_chk();
      send(8'h03, 3'h4, $urandom);
      chk_byte(rsp, 8'hFF);
      en();
      status_write_cmd(8'h80, 3'h1);
      @(negedge ref_clk_in) wp_n_in = 1'b0;
      en();
      status_write_cmd(8'h0C, 3'h1);
      chk_byte({7'h00, hard_protect_out}, 8'h01);
      @(negedge ref_clk_in) wp_n_in = 1'b1;
      // The lock is still set here, so only the pin can have ended the protection.
      repeat (4) @(negedge ref_clk_in);
      chk_byte({7'h00, hard_protect_out}, 8'h00);
      status_write_cmd(8'h00, 3'h1);
      @(negedge ref_clk_in) wp_n_in = 1'b0;
      for (int s = 0; s < 4; s++) begin
         en();
         status_write_cmd({4'h0, 2'(s), 2'h0}, 3'h1);
         for (int k = 0; k < 5; k++) begin
            if (k < 4) en();
            memwr(k < 4 ? ADDRS[k] : 17'($urandom));
         end
      end
      en();
      status_write_cmd(8'h80, 3'h1);
      en();
      status_write_cmd(8'h00, 3'h1);
      chk_byte({7'h00, hard_protect_out}, 8'h01);
      chk_byte({5'h00, nv_stored_out}, {5'h00, lock, sel});
      summarize();
   end
endmodule : tb
